// ### hdl/tt_throttle_ctrl.sv
// Thermal throttle controller with Wishbone register access
`timescale 1ns/10ps
`include "tt_defines.svh"
// Notes on behaviour
// - Frequency-voltage throttling engages for both cores on high temperature when enabled.
// - Engaged engine lowers bus ratio and drives a lower voltage code.
// - Normal point uses software max ratio and nominal voltage code.
// - Reduced point uses ratio 6; frequency change starts on engagement.
// - Frequency change lasts about 5 us; bus requests held off meanwhile.
// - Edge interrupts during frequency change are latched, delivered afterwards.
// - After lower frequency, voltage code steps one entry at a time.
// - Cores keep running while the voltage code steps.
// - Return to normal only after cooling and hysteresis timer expiry.
// - On return, voltage code restored first, frequency raised after.
// - Alert output follows high temperature regardless of throttle enables.
// - Soft duty enable bit 4 gates core clock at once, temperature ignored.
// - Bits 3:1 pick clock-on duty in 12.5% steps, 12.5% to 87.5%.
// - Fixed factory duty overrides soft duty while fixed gating is active.
// - Alert when any core trips; with monitoring on, engine active then.
// - Optional interrupt on rising or falling alert output.
// - Force input engages engine for all cores until deasserted, monitoring on.
// - Force input is asynchronous and synchronised before use.
// - Force input alone never asserts the alert output.
// - Catastrophic overtemperature shuts down and drives shutdown output, no bus cycle.
// - With both features on, frequency-voltage first, fixed gating added if ineffective.
module tt_throttle_ctrl #(
  parameter int NCORE = 2,
  parameter int NIRQ = 4,
  parameter int HYST_CYC = `TT_HYST_CYC,
  parameter int ESC_CYC = `TT_ESC_CYC,
  parameter int FREQ_CHG_CYC = `TT_FREQ_CHG_CYC,
  parameter int CODE_STEP_CYC = `TT_CODE_STEP_CYC,
  parameter int SLOT_CYC = `TT_SLOT_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Sensor and platform inputs, asynchronous
  input wire logic [NCORE-1:0] core_hot_i,
  input wire logic core_trip_i,
  input wire logic force_throttle_in_n_i,
  input wire logic [NIRQ-1:0] ext_irq_i,
  // Operating point to clock generator and regulator
  output logic [7:0] bus_ratio_o,
  output logic [7:0] voltage_id_code_o,
  // Core control
  output logic host_bus_hold_o,
  output logic core_clk_en_o,
  output logic core_halt_o,
  output logic [NIRQ-1:0] irq_deliver_o,
  // Thermal signalling
  output logic thermal_alert_out_n_o,
  output logic thermal_shutdown_out_n_o,
  output logic alert_irq_o
);

  localparam int TW = 18;
  localparam logic [TW-1:0] FREQ_LAST = TW'(FREQ_CHG_CYC - 1);
  localparam logic [TW-1:0] STEP_LAST = TW'(CODE_STEP_CYC - 1);
  localparam logic [TW-1:0] HYST_LAST = TW'(HYST_CYC);
  localparam logic [TW-1:0] ESC_LAST = TW'(ESC_CYC);

  // One code entry toward the target
  function automatic tt_pkg::tt_code_t code_step(input tt_pkg::tt_code_t cur,
                                                 input tt_pkg::tt_code_t tgt);
    if (cur < tgt) begin
      code_step = cur + 8'h01;
    end else if (cur > tgt) begin
      code_step = cur - 8'h01;
    end else begin
      code_step = cur;
    end
  endfunction

  // Byte-lane write merge
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] wr,
                                             input logic [3:0] sel);
    integer i;
    lane_merge = old;
    for (i = 0; i < 4; i = i + 1) begin
      if (sel[i]) begin
        lane_merge[8*i +: 8] = wr[8*i +: 8];
      end
    end
  endfunction

  // Synchronised inputs
  logic [NCORE-1:0] hot_s;
  logic trip_s;
  logic force_n_s;
  logic [NIRQ-1:0] irq_s;

  tt_sync #(.W(NCORE), .RST_VAL('0)) u_sync_hot (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(core_hot_i),
    .q_o(hot_s)
  );

  tt_sync #(.W(2), .RST_VAL(2'b01)) u_sync_pins (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({core_trip_i, force_throttle_in_n_i}),
    .q_o({trip_s, force_n_s})
  );

  tt_sync #(.W(NIRQ), .RST_VAL('0)) u_sync_irq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(ext_irq_i),
    .q_o(irq_s)
  );

  // Software registers
  logic [`TT_CTRL_W-1:0] ctrl_r;
  logic [7:0] max_ratio_r;
  logic [4:0] duty_r;
  logic [7:0] vnom_r;
  logic [7:0] vlow_r;
  logic ack_r;

  // Engine state
  tt_pkg::tt_state_t state_r;
  tt_pkg::tt_state_t state_nxt;
  logic [TW-1:0] tmr_r;
  logic [TW-1:0] tmr_nxt;
  logic [7:0] ratio_r;
  logic [7:0] ratio_nxt;
  tt_pkg::tt_code_t code_r;
  tt_pkg::tt_code_t code_nxt;
  logic [TW-1:0] cool_r;
  logic [TW-1:0] esc_r;
  logic gate_fixed_r;
  logic alert_r;
  logic shut_r;
  logic [NIRQ-1:0] irq_prev_r;
  logic [NIRQ-1:0] irq_pend_r;
  logic duty_on;

  // Bus decode
  wire bus_req = wb_cyc_i && wb_stb_i && !ack_r;
  wire bus_wr = bus_req && wb_we_i;
  wire hit_ctrl = (wb_adr_i == `TT_ADR_CTRL);
  wire hit_ratio = (wb_adr_i == `TT_ADR_RATIO);
  wire hit_duty = (wb_adr_i == `TT_ADR_DUTY);
  wire hit_vnom = (wb_adr_i == `TT_ADR_VNOM);
  wire hit_vlow = (wb_adr_i == `TT_ADR_VLOW);
  wire hit_stat = (wb_adr_i == `TT_ADR_STAT);

  // Throttle requests
  wire fixed_en = ctrl_r[`TT_CTRL_FIXED_EN];
  wire fv_en = ctrl_r[`TT_CTRL_FV_EN];
  wire hot_any = |hot_s;
  wire force_act = !force_n_s;
  wire mon_en = fixed_en || fv_en;
  wire req = mon_en && (hot_any || force_act);
  wire fv_req = fv_en && req;
  wire cool_done = (cool_r == HYST_LAST);
  wire esc_done = (esc_r == ESC_LAST);
  wire freq_chg = (state_r == tt_pkg::ST_FREQ_DN) || (state_r == tt_pkg::ST_FREQ_UP);
  wire step_due = (tmr_r == STEP_LAST);
  wire engaged = (state_r != tt_pkg::ST_NORMAL) || gate_fixed_r;

  // Fixed gating: alone when only it is enabled, else after escalation
  wire gate_set = req && fixed_en && (!fv_en || esc_done);
  wire gate_clr = !req && cool_done;

  // Duty selection
  wire soft_en = duty_r[`TT_DUTY_EN];
  wire [2:0] soft_duty = duty_r[`TT_DUTY_HI:`TT_DUTY_LO];
  wire [2:0] soft_eff = (soft_duty == 3'h0) ? `TT_SOFT_DUTY_DFLT : soft_duty;
  wire mod_active = gate_fixed_r || soft_en;
  wire [2:0] duty_sel = gate_fixed_r ? `TT_FIXED_DUTY : soft_eff;

  // Interrupt edges
  wire [NIRQ-1:0] irq_rise = irq_s & ~irq_prev_r;
  wire [NIRQ-1:0] irq_give = freq_chg ? '0 : irq_pend_r;

  tt_duty_gen #(.SLOT_CYC(SLOT_CYC)) u_duty (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .active_i(mod_active),
    .on_eighths_i(duty_sel),
    .on_o(duty_on)
  );

  // Engine sequencing
  always_comb begin
    state_nxt = state_r;
    tmr_nxt = tmr_r + TW'(1);
    ratio_nxt = ratio_r;
    code_nxt = code_r;
    case (state_r)
      tt_pkg::ST_NORMAL: begin
        ratio_nxt = max_ratio_r;
        code_nxt = vnom_r;
        tmr_nxt = '0;
        if (fv_req) begin
          state_nxt = tt_pkg::ST_FREQ_DN;
          ratio_nxt = `TT_MIN_RATIO;
        end
      end
      tt_pkg::ST_FREQ_DN: begin
        if (tmr_r == FREQ_LAST) begin
          state_nxt = tt_pkg::ST_CODE_DN;
          tmr_nxt = '0;
        end
      end
      tt_pkg::ST_CODE_DN: begin
        if (code_r == vlow_r) begin
          state_nxt = tt_pkg::ST_LOW;
        end else if (step_due) begin
          code_nxt = code_step(code_r, vlow_r);
          tmr_nxt = '0;
        end
      end
      tt_pkg::ST_LOW: begin
        tmr_nxt = '0;
        if (!req && cool_done) begin
          state_nxt = tt_pkg::ST_CODE_UP;
        end
      end
      tt_pkg::ST_CODE_UP: begin
        if (fv_req) begin
          state_nxt = tt_pkg::ST_CODE_DN;
          tmr_nxt = '0;
        end else if (code_r == vnom_r) begin
          state_nxt = tt_pkg::ST_FREQ_UP;
          ratio_nxt = max_ratio_r;
          tmr_nxt = '0;
        end else if (step_due) begin
          code_nxt = code_step(code_r, vnom_r);
          tmr_nxt = '0;
        end
      end
      tt_pkg::ST_FREQ_UP: begin
        if (tmr_r == FREQ_LAST) begin
          state_nxt = tt_pkg::ST_NORMAL;
          tmr_nxt = '0;
        end
      end
      tt_pkg::ST_SHUT: begin
        tmr_nxt = '0;
      end
      default: begin
        state_nxt = tt_pkg::ST_NORMAL;
        tmr_nxt = '0;
      end
    endcase
    if (trip_s) begin
      state_nxt = tt_pkg::ST_SHUT;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= tt_pkg::ST_NORMAL;
      tmr_r <= '0;
      ratio_r <= `TT_RST_RATIO;
      code_r <= `TT_RST_VNOM;
    end else begin
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
      ratio_r <= ratio_nxt;
      code_r <= code_nxt;
    end
  end

  // Hysteresis and escalation timers
  always_ff @(posedge clk_i) begin
    if (rst_i || req) begin
      cool_r <= '0;
    end else if (!cool_done) begin
      cool_r <= cool_r + TW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !req || state_r != tt_pkg::ST_LOW) begin
      esc_r <= '0;
    end else if (!esc_done) begin
      esc_r <= esc_r + TW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_fixed_r <= 1'b0;
    end else if (gate_set) begin
      gate_fixed_r <= 1'b1;
    end else if (gate_clr || !fixed_en) begin
      gate_fixed_r <= 1'b0;
    end
  end

  // Alert, shutdown and alert interrupt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alert_r <= 1'b0;
      shut_r <= 1'b0;
      alert_irq_o <= 1'b0;
    end else begin
      alert_r <= hot_any;
      shut_r <= shut_r || trip_s;
      alert_irq_o <= (hot_any && !alert_r && ctrl_r[`TT_CTRL_IRQ_RISE]) ||
                     (!hot_any && alert_r && ctrl_r[`TT_CTRL_IRQ_FALL]);
    end
  end

  // Edge interrupts held while the frequency changes; set wins over delivery
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_prev_r <= '0;
      irq_pend_r <= '0;
      irq_deliver_o <= '0;
    end else begin
      irq_prev_r <= irq_s;
      irq_pend_r <= (irq_pend_r & ~irq_give) | irq_rise;
      irq_deliver_o <= irq_give;
    end
  end

  // Registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_ratio_o <= `TT_RST_RATIO;
      voltage_id_code_o <= `TT_RST_VNOM;
      host_bus_hold_o <= 1'b0;
      core_clk_en_o <= 1'b1;
      core_halt_o <= 1'b0;
      thermal_alert_out_n_o <= 1'b1;
      thermal_shutdown_out_n_o <= 1'b1;
    end else begin
      bus_ratio_o <= ratio_r;
      voltage_id_code_o <= code_r;
      host_bus_hold_o <= freq_chg;
      core_clk_en_o <= duty_on && !freq_chg && !shut_r;
      core_halt_o <= shut_r;
      thermal_alert_out_n_o <= !alert_r;
      thermal_shutdown_out_n_o <= !shut_r;
    end
  end

  // Status word
  wire [31:0] stat_word = {8'h00, code_r, ratio_r, 2'b00, freq_chg, shut_r, gate_fixed_r,
                           engaged, force_act, alert_r};

  wire [31:0] rd_word = hit_ctrl ? 32'(ctrl_r) :
                        hit_ratio ? 32'(max_ratio_r) :
                        hit_duty ? 32'(duty_r) :
                        hit_vnom ? 32'(vnom_r) :
                        hit_vlow ? 32'(vlow_r) :
                        hit_stat ? stat_word : 32'h00000000;

  // Addressed register with the selected lanes replaced
  wire [31:0] wr_word = lane_merge(rd_word, wb_dat_i, wb_sel_i);

  // Register writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= `TT_RST_CTRL;
      max_ratio_r <= `TT_RST_RATIO;
      duty_r <= `TT_RST_DUTY;
      vnom_r <= `TT_RST_VNOM;
      vlow_r <= `TT_RST_VLOW;
    end else if (bus_wr) begin
      if (hit_ctrl) begin
        ctrl_r <= wr_word[`TT_CTRL_W-1:0];
      end else if (hit_ratio) begin
        max_ratio_r <= wr_word[7:0];
      end else if (hit_duty) begin
        duty_r <= wr_word[4:0];
      end else if (hit_vnom) begin
        vnom_r <= wr_word[7:0];
      end else if (hit_vlow) begin
        vlow_r <= wr_word[7:0];
      end
    end
  end

  // Single-cycle acknowledge, also for unmapped addresses
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      ack_r <= bus_req;
      wb_dat_o <= bus_req ? rd_word : 32'h00000000;
    end
  end

  assign wb_ack_o = ack_r;

endmodule

// ### hdl/tt_defines.svh
// Register map, field positions, reset values and timing counts
`ifndef TT_DEFINES_SVH
`define TT_DEFINES_SVH

// Register byte offsets
`define TT_ADR_CTRL 8'h00
`define TT_ADR_RATIO 8'h04
`define TT_ADR_DUTY 8'h08
`define TT_ADR_VNOM 8'h0C
`define TT_ADR_VLOW 8'h10
`define TT_ADR_STAT 8'h14

// Control fields
`define TT_CTRL_FIXED_EN 0
`define TT_CTRL_FV_EN 1
`define TT_CTRL_IRQ_RISE 2
`define TT_CTRL_IRQ_FALL 3
`define TT_CTRL_W 4

// Soft duty control fields
`define TT_DUTY_EN 4
`define TT_DUTY_HI 3
`define TT_DUTY_LO 1

// Status fields
`define TT_STAT_ALERT 0
`define TT_STAT_FORCE 1
`define TT_STAT_ENGAGED 2
`define TT_STAT_GATING 3
`define TT_STAT_SHUT 4
`define TT_STAT_HOLD 5
`define TT_STAT_RATIO_LO 8
`define TT_STAT_CODE_LO 16

// Reset values
`define TT_RST_CTRL 4'h3
`define TT_RST_RATIO 8'h0C
`define TT_RST_DUTY 5'h00
`define TT_RST_VNOM 8'h20
`define TT_RST_VLOW 8'h28

// Operating constants
`define TT_MIN_RATIO 8'h06
`define TT_FIXED_DUTY 3'h4
`define TT_SOFT_DUTY_DFLT 3'h4

// Timing, clock at 50 MHz
`define TT_CLK_MHZ 50
`define TT_FREQ_CHG_NS 5000
`define TT_FREQ_CHG_CYC ((`TT_FREQ_CHG_NS * `TT_CLK_MHZ) / 1000)
`define TT_CODE_STEP_NS 1000
`define TT_CODE_STEP_CYC ((`TT_CODE_STEP_NS * `TT_CLK_MHZ) / 1000)
`define TT_HYST_US 1000
`define TT_HYST_CYC (`TT_HYST_US * `TT_CLK_MHZ)
`define TT_ESC_US 2000
`define TT_ESC_CYC (`TT_ESC_US * `TT_CLK_MHZ)
`define TT_SLOT_NS 200
`define TT_SLOT_CYC ((`TT_SLOT_NS * `TT_CLK_MHZ) / 1000)

`endif

// ### hdl/tt_pkg.sv
// Types shared by the thermal throttle files
package tt_pkg;

  typedef enum logic [6:0] {
    ST_NORMAL  = 7'b0000001,
    ST_FREQ_DN = 7'b0000010,
    ST_CODE_DN = 7'b0000100,
    ST_LOW     = 7'b0001000,
    ST_CODE_UP = 7'b0010000,
    ST_FREQ_UP = 7'b0100000,
    ST_SHUT    = 7'b1000000
  } tt_state_t;

  typedef logic [7:0] tt_code_t;

endpackage

// ### hdl/tt_sync.sv
// Two-flop synchroniser for asynchronous levels
`timescale 1ns/10ps
module tt_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end

endmodule

// ### hdl/tt_duty_gen.sv
// Core clock duty modulator, eight phases per period
`timescale 1ns/10ps
module tt_duty_gen #(
  parameter int SLOT_CYC = 10
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic active_i,
  input wire logic [2:0] on_eighths_i,
  // Gate
  output logic on_o
);

  localparam int SW = (SLOT_CYC > 1) ? $clog2(SLOT_CYC) : 1;
  localparam logic [SW-1:0] SLOT_LAST = SW'(SLOT_CYC - 1);

  logic [SW-1:0] slot_r;
  logic [2:0] phase_r;
  wire slot_end = (slot_r == SLOT_LAST);

  always_ff @(posedge clk_i) begin
    if (rst_i || !active_i) begin
      slot_r <= '0;
      phase_r <= 3'h0;
    end else begin
      slot_r <= slot_end ? '0 : slot_r + SW'(1);
      phase_r <= slot_end ? phase_r + 3'h1 : phase_r;
    end
  end

  // Clock on for the first on_eighths phases of each period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      on_o <= 1'b1;
    end else begin
      on_o <= !active_i || (phase_r < on_eighths_i);
    end
  end

endmodule

// ### tb/tt_throttle_chk.sv
// Port assertions for the thermal throttle controller
`timescale 1ns/10ps
`include "tt_defines.svh"
module tt_throttle_chk #(
  parameter int NCORE = 2,
  parameter int NIRQ = 4,
  parameter int FREQ_CHG_CYC = 250
) (
  // Clock, reset, bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Thermal inputs and outputs
  input wire logic [NCORE-1:0] core_hot_i,
  input wire logic core_trip_i,
  input wire logic [7:0] bus_ratio_o,
  input wire logic [7:0] voltage_id_code_o,
  input wire logic host_bus_hold_o,
  input wire logic core_clk_en_o,
  input wire logic core_halt_o,
  input wire logic [NIRQ-1:0] irq_deliver_o,
  input wire logic thermal_alert_out_n_o,
  input wire logic thermal_shutdown_out_n_o
);
  logic [15:0] hold_cnt_r;
  always_ff @(posedge clk_i) begin
    if (rst_i || !host_bus_hold_o) begin
      hold_cnt_r <= 16'h0000;
    end else begin
      hold_cnt_r <= hold_cnt_r + 16'h0001;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_hot; (|core_hot_i) [*5]; endsequence
  sequence s_cool; (core_hot_i == '0) [*5]; endsequence
  sequence s_trip; core_trip_i [*5]; endsequence
  a_alert_on_hot: assert property (s_hot |-> !thermal_alert_out_n_o)
    else $error("alert missing while hot");
  a_alert_only_hot: assert property (s_cool |-> thermal_alert_out_n_o)
    else $error("alert without heat");
  a_trip_shuts_down: assert property (s_trip |-> !thermal_shutdown_out_n_o && core_halt_o)
    else $error("no shutdown on trip");
  a_shutdown_latched: assert property (!thermal_shutdown_out_n_o |=>
    !thermal_shutdown_out_n_o && core_halt_o && !core_clk_en_o)
    else $error("shutdown released");
  a_ratio_under_hold: assert property ($changed(bus_ratio_o) && (bus_ratio_o ==
    `TT_MIN_RATIO || $past(bus_ratio_o) == `TT_MIN_RATIO) |-> host_bus_hold_o)
    else $error("ratio moved without hold");
  a_hold_length: assert property ($fell(host_bus_hold_o) |->
    hold_cnt_r + 2 >= FREQ_CHG_CYC && hold_cnt_r <= FREQ_CHG_CYC + 2)
    else $error("hold length wrong");
  a_code_one_step: assert property ($changed(voltage_id_code_o) |->
    voltage_id_code_o - $past(voltage_id_code_o) inside {8'h01, 8'hFF})
    else $error("code jumped");
  a_code_at_low: assert property ($changed(voltage_id_code_o) |->
    bus_ratio_o == `TT_MIN_RATIO && !host_bus_hold_o && !core_halt_o)
    else $error("code moved off low ratio");
  a_code_before_ratio: assert property ($changed(bus_ratio_o) &&
    $past(bus_ratio_o) == `TT_MIN_RATIO |-> voltage_id_code_o == `TT_RST_VNOM)
    else $error("ratio raised before code");
  a_irq_pending: assert property (host_bus_hold_o && $past(host_bus_hold_o) |->
    irq_deliver_o == '0)
    else $error("irq delivered in change");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
endmodule
bind tt_throttle_ctrl tt_throttle_chk #(.NCORE(NCORE), .NIRQ(NIRQ),
  .FREQ_CHG_CYC(FREQ_CHG_CYC)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .core_hot_i(core_hot_i),
  .core_trip_i(core_trip_i), .bus_ratio_o(bus_ratio_o),
  .voltage_id_code_o(voltage_id_code_o), .host_bus_hold_o(host_bus_hold_o),
  .core_clk_en_o(core_clk_en_o), .core_halt_o(core_halt_o), .irq_deliver_o(irq_deliver_o),
  .thermal_alert_out_n_o(thermal_alert_out_n_o),
  .thermal_shutdown_out_n_o(thermal_shutdown_out_n_o));

// ### tb/tt_platform_model.sv
// Platform regulator and force-throttle driver model
`timescale 1ns/10ps
module tt_platform_model #(
  parameter int MIN_HOLD = 300
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bench request, regulator input
  input wire logic force_req_i,
  input wire logic [7:0] voltage_id_code_i,
  // Platform side
  output logic force_throttle_in_n_o,
  output logic [7:0] vr_code_o,
  output logic vr_jump_o
);
  logic [15:0] held_r;
  wire logic hold_done = held_r >= 16'(MIN_HOLD);
  wire logic [7:0] diff = voltage_id_code_i - vr_code_o;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      force_throttle_in_n_o <= 1'b1;
      held_r <= 16'h0000;
      vr_code_o <= voltage_id_code_i;
      vr_jump_o <= 1'b0;
    end else begin
      // Regulator follows every code; jumps beyond one step are flagged
      vr_code_o <= voltage_id_code_i;
      if (!(diff inside {8'h00, 8'h01, 8'hFF})) begin
        vr_jump_o <= 1'b1;
      end
      if (force_req_i || (!force_throttle_in_n_o && !hold_done)) begin
        force_throttle_in_n_o <= 1'b0;
        held_r <= force_throttle_in_n_o ? 16'h0000 : held_r + 16'h0001;
      end else begin
        force_throttle_in_n_o <= 1'b1;
      end
    end
  end
endmodule

// ### tb/tt_throttle_ctrl_tb.sv
// Self-checking bench for the thermal throttle controller
`timescale 1ns/10ps
`include "tt_defines.svh"
module tt_throttle_ctrl_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic trip = 1'b0;
  logic force_req = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h00000000;
  logic [1:0] hot = 2'h0;
  logic [3:0] irq_in = 4'h0;
  logic [3:0] sel = 4'hF;
  logic [31:0] rdat, rd;
  logic [3:0] irq_dl;
  logic [7:0] ratio, code, vr_code;
  logic ack, hold, clk_en, halt, alert_n, shut_n, alert_irq, force_n, vr_jump;
  int fail_count = 0;
  int checks = 0;
  int irq_seen = 0;
  int alert_seen = 0;
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    irq_seen <= irq_seen + irq_dl[0];
    alert_seen <= alert_seen + alert_irq;
  end
  tt_throttle_ctrl #(.HYST_CYC(20), .ESC_CYC(40), .FREQ_CHG_CYC(25), .CODE_STEP_CYC(5),
    .SLOT_CYC(2)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .core_hot_i(hot), .core_trip_i(trip), .force_throttle_in_n_i(force_n),
    .ext_irq_i(irq_in), .bus_ratio_o(ratio), .voltage_id_code_o(code),
    .host_bus_hold_o(hold), .core_clk_en_o(clk_en), .core_halt_o(halt),
    .irq_deliver_o(irq_dl), .thermal_alert_out_n_o(alert_n),
    .thermal_shutdown_out_n_o(shut_n), .alert_irq_o(alert_irq));
  tt_platform_model u_plat (.clk_i(clk_i), .rst_i(rst_i),
    .force_req_i(force_req), .voltage_id_code_i(code), .force_throttle_in_n_o(force_n),
    .vr_code_o(vr_code), .vr_jump_o(vr_jump));
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge clk_i);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      fail_count++;
      summarize();
    end
  endtask
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h00000000);
    chk(name, exp, rd);
  endtask
  task automatic wait8(input logic [7:0] v, input logic of_code);
    int n;
    for (n = 0; n < 3000 && (of_code ? code : ratio) !== v; n++) @(posedge clk_i);
    if (n == 3000) begin
      fail_count++;
      summarize();
    end
  endtask
  task automatic count_on(output int c);
    c = 0;
    repeat (160) begin
      @(posedge clk_i);
      c += int'(clk_en === 1'b1);
    end
  endtask
  initial begin
    int c;
    int d;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("ctrl", `TT_ADR_CTRL, 32'h00000003);
    rd_chk("ratio reg", `TT_ADR_RATIO, 32'h0000000C);
    rd_chk("duty reg", `TT_ADR_DUTY, 32'h00000000);
    rd_chk("low code reg", `TT_ADR_VLOW, 32'h00000028);
    rd_chk("nominal code reg", `TT_ADR_VNOM, 32'h00000020);
    rd_chk("unmapped", 8'h40, 32'h00000000);
    chk("code", `TT_RST_VNOM, code);
    chk("shutdown", 32'h1, shut_n);
    wb(1'b1, `TT_ADR_RATIO, 32'h0000000A);
    wb(1'b1, `TT_ADR_CTRL, 32'h00000007);
    wait8(8'h0A, 1'b0);
    chk("ratio normal", 32'h0A, ratio);
    sel <= 4'h2;
    wb(1'b1, `TT_ADR_RATIO, 32'h000000FF);
    sel <= 4'hF;
    rd_chk("ratio lanes", `TT_ADR_RATIO, 32'h0000000A);
    $display("test registers done");
    @(posedge clk_i) hot <= 2'b10;
    wait8(`TT_MIN_RATIO, 1'b0);
    chk("hold", 32'h1, hold);
    @(posedge clk_i) irq_in <= 4'h1;
    @(posedge clk_i) irq_in <= 4'h0;
    repeat (3) @(posedge clk_i);
    chk("irq pending", 32'h0, irq_seen);
    wait8(8'h28, 1'b1);
    chk("irq delivered", 32'h1, irq_seen);
    chk("alert", 32'h0, alert_n);
    chk("alert irq rise", 32'h1, alert_seen);
    wb(1'b1, `TT_ADR_CTRL, 32'h0000000B);
    @(posedge clk_i) hot <= 2'b00;
    repeat (12) @(posedge clk_i);
    chk("code held", 32'h28, code);
    chk("alert irq fall", 32'h2, alert_seen);
    wait8(8'h0A, 1'b0);
    chk("code restored", `TT_RST_VNOM, code);
    $display("test heat done");
    wb(1'b1, `TT_ADR_DUTY, 32'h00000012);
    @(posedge clk_i) force_req <= 1'b1;
    wait8(`TT_MIN_RATIO, 1'b0);
    chk("alert under force", 32'h1, alert_n);
    wait8(8'h28, 1'b1);
    repeat (60) @(posedge clk_i);
    count_on(c);
    chk("fixed duty", 32'd80, c);
    rd_chk("status", `TT_ADR_STAT, 32'h0028060E);
    chk("still engaged", `TT_MIN_RATIO, ratio);
    @(posedge clk_i) force_req <= 1'b0;
    wait8(8'h0A, 1'b0);
    repeat (30) @(posedge clk_i);
    chk("hold released", 32'h0, hold);
    $display("test force done");
    wb(1'b1, `TT_ADR_CTRL, 32'h00000001);
    @(posedge clk_i) force_req <= 1'b1;
    repeat (20) @(posedge clk_i);
    count_on(c);
    chk("fixed only duty", 32'd80, c);
    chk("fixed only ratio", 32'h0A, ratio);
    @(posedge clk_i) force_req <= 1'b0;
    repeat (200) @(posedge clk_i);
    $display("test fixed gating done");
    for (d = 1; d < 8; d++) begin
      wb(1'b1, `TT_ADR_DUTY, 32'h00000010 | 32'(d << 1));
      repeat (16) @(posedge clk_i);
      count_on(c);
      chk("soft duty", 32'(20 * d), c);
    end
    wb(1'b1, `TT_ADR_DUTY, 32'h00000000);
    repeat (2) @(posedge clk_i);
    count_on(c);
    chk("duty off", 32'd160, c);
    chk("regulator steps", 32'h0, vr_jump);
    $display("test duty done");
    @(posedge clk_i) trip <= 1'b1;
    repeat (5) @(posedge clk_i);
    trip <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk("shutdown", 32'h0, shut_n);
    chk("halt", 32'h1, halt);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("shutdown cleared", 32'h1, shut_n);
    $display("test shutdown done");
    summarize();
  end
endmodule
